/* hdl/pcs_pkg.sv */
// Constants and types for the PWM clock, sync and GPIO control block.
// Assumes a 100 MHz system clock and an external clock on its own port.
package pcs_pkg;
  // ==========================================================
  // Timing
  localparam int CLOCK_MHZ = 100;
  localparam int MIN_ON_NS = 40;
  localparam int MIN_ON_CYCLES = (MIN_ON_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] MIN_ON_TICKS = 8'(MIN_ON_CYCLES);
  localparam logic [7:0] SAMPLE_TICKS = 8'h10;
  localparam logic [9:0] MEAS_LAST = 10'h3_FF;
  // ==========================================================
  // Rate select fields
  localparam int OSC_SEL_LSB = 4;
  localparam int DIV_SEL_LSB = 0;
  localparam int PERIOD_SHIFT = 5;
  // ==========================================================
  // Sync mode bits
  localparam int SYNC_USE_EXT = 0;
  localparam int SYNC_MASTER = 1;
  localparam int SYNC_AUTO_BACK = 2;
  // ==========================================================
  // Pins and rails
  localparam int PINS = 6;
  localparam int RAILS = 5;
  localparam int CHANNELS = 4;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] POL_I2C_MASK = 8'h0F;
  localparam logic [7:0] POL_MASK = 8'h3F;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    PCS_FN_NONE, PCS_FN_RAIL_EN, PCS_FN_PWR_GOOD, PCS_FN_CLK_OUT, PCS_FN_SYNC_OUT
  } pcs_pin_fn_t;
  typedef enum logic [2:0] {
    PCS_BOOT, PCS_INTERNAL, PCS_MEASURE, PCS_ARMED, PCS_EXTERNAL
  } pcs_src_t;
endpackage : pcs_pkg

/* hdl/pcs_ctrl.sv */
// Switching timing, clock source selection, master/slave forwarding and GPIO functions.
// Configuration arrives as levels from the serial or OTP loader on the system clock;
// the external clock arrives on link_clock and is crossed by a toggle.
`timescale 1ns/1ps
// How it works
// [R1] A non-zero pulse is never shorter than the 40 ns minimum on-time.
// [R2] Sixteen ticks of each period stay low-side for current sampling.
// [R3] Duty is capped by the tabulated maximum for the divider row.
// [R4] Each channel clamps its requested duty at its own limit setting.
// [R5] Host should program each limit with the tabulated maximum duty.
// [R6] Sync mode selects external clock, master or slave, and auto switch-back.
// [R7] After reset the block always runs from the internal oscillator first.
// [R8] External clock is adopted only if its edge count sits in the window.
// [R9] Without a clock in the window the internal clock stays in use.
// [R10] With auto switch-back a failed external clock reverts to internal.
// [R11] A master drives clock and sync outputs once configuration has loaded.
// [R12] A slave boots internal, then takes the master clock as main clock.
// [R13] External clock feeds both units or only the master, which forwards it.
// [R14] Channel phase steps of 90 or 120 degrees; channels may share one.
// [R15] Pin functions come from OTP bits or from serial writes.
// [R16] Six polarity bits invert GPIO zero to five, input or output.
// [R17] In serial mode polarity bits five and four have no effect.
// [R18] A rail-enable pin turns its mapped rails on and off; serial can too.
// [R19] Power-good pin asserts only while all mapped rails regulate; also readable.
// [R20] Rate select holds oscillator and divider fields; divider zero is invalid.
// [R21] Internal oscillator should be set within a few percent of the external.
// [R22] Switch to external waits for an internal period boundary but can cut phase-shifted pulses; a return to internal restarts the period at once.
// [R23] Rail-enable pins pass a two-stage synchroniser before use.
module pcs_ctrl (
  // Clocks and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic link_clock,
  // Configuration
  input wire logic config_loaded,
  input wire logic i2c_mode,
  input wire logic [7:0] switching_rate_select,
  input wire logic [2:0] sync_mode,
  input wire logic [7:0] sync_expect_count,
  input wire logic [4:0] sync_window_pct,
  input wire logic phase_mode_three,
  input wire logic [3:0][1:0] phase_index,
  input wire logic [3:0][7:0] channel_duty_limit,
  input wire logic [3:0][7:0] duty_request,
  input wire logic [7:0] pin_polarity,
  input wire logic [5:0][2:0] otp_pin_function,
  input wire logic [5:0][2:0] i2c_pin_function,
  input wire logic [5:0][4:0] pin_rail_map,
  input wire logic [4:0] i2c_rail_enable,
  input wire logic [4:0] rail_in_regulation,
  // GPIO pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  // Modulator and rails
  output logic [3:0] high_side,
  output logic [3:0] low_side,
  output logic [4:0] rail_enable,
  output logic [4:0] rail_good_status,
  // Status
  output logic on_external
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    pcs_pkg::pcs_src_t src;
    logic [9:0] meas_cnt;
    logic [10:0] edge_cnt;
    logic [7:0] period_cnt;
    logic clk_fwd;
    logic sync_pulse;
    logic [3:0] high_side;
    logic [3:0] low_side;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [4:0] rail_enable;
    logic [4:0] rail_good;
  } pcs_state_t;

  pcs_state_t state;
  pcs_state_t next_state;
  logic link_toggle;

  function automatic logic [7:0] pcs_min8(input logic [7:0] a, input logic [7:0] b);
    pcs_min8 = (a < b) ? a : b;
  endfunction : pcs_min8

  // Table maximum duty in percent per divider row
  function automatic logic [6:0] pcs_max_pct(input logic [2:0] div);
    case (div)
      3'h1: pcs_max_pct = 7'd47;
      3'h2: pcs_max_pct = 7'd64;
      3'h3: pcs_max_pct = 7'd72;
      3'h4: pcs_max_pct = 7'd77;
      3'h5: pcs_max_pct = 7'd80;
      3'h6: pcs_max_pct = 7'd83;
      3'h7: pcs_max_pct = 7'd85;
      default: pcs_max_pct = 7'd0;
    endcase
  endfunction : pcs_max_pct

  // ==========================================================
  // Link domain: one toggle per external edge, crossed as an event
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      link_toggle <= 1'b0;
    end else begin
      link_toggle <= ~link_toggle;
    end
  end

  // ==========================================================
  // Period geometry
  logic [2:0] div_sel;
  logic div_ok;
  logic [7:0] period;
  logic [7:0] period_last;
  logic [7:0] table_on;
  logic [7:0] sample_on;
  logic [14:0] table_prod;
  logic running;

  assign div_sel = switching_rate_select[pcs_pkg::DIV_SEL_LSB +: 3];
  assign div_ok = (div_sel != 3'h0); // [R20]
  assign period = 8'({div_sel, 5'h00});
  assign period_last = period - 8'h01;
  assign table_prod = 15'(period) * 15'(pcs_max_pct(div_sel));
  assign table_on = 8'(table_prod / 15'd100); // [R3]
  assign sample_on = (period > pcs_pkg::SAMPLE_TICKS) ? period - pcs_pkg::SAMPLE_TICKS : 8'h00;
  assign running = div_ok && config_loaded && (state.src != pcs_pkg::PCS_BOOT);

  // ==========================================================
  // Per-channel on-time and phase position
  logic [3:0] ch_high;
  genvar gi;
  generate
    for (gi = 0; gi < pcs_pkg::CHANNELS; gi++) begin : g_ch
      logic [7:0] limit;
      logic [7:0] req;
      logic [7:0] on_time;
      logic [7:0] offset;
      logic [7:0] pos;
      logic [9:0] third;
      assign limit = pcs_min8(channel_duty_limit[gi], pcs_min8(table_on, sample_on)); // [R4]
      // Zero stays zero; anything shorter is lifted to the minimum pulse
      assign req = (duty_request[gi] == 8'h00) ? 8'h00
                 : (duty_request[gi] < pcs_pkg::MIN_ON_TICKS) ? pcs_pkg::MIN_ON_TICKS
                 : duty_request[gi]; // [R1]
      // A limit below the minimum pulse would only make runts, so it blanks the channel
      assign on_time = (limit < pcs_pkg::MIN_ON_TICKS) ? 8'h00 : pcs_min8(req, limit); // [R1]
      assign third = 10'(period / 8'd3) * 10'(phase_index[gi]);
      // Equal indices share one phase
      assign offset = phase_mode_three
                    ? ((phase_index[gi] == 2'h3) ? 8'h00 : 8'(third))
                    : 8'(10'(period >> 2) * 10'(phase_index[gi])); // [R14]
      assign pos = (state.period_cnt >= offset) ? state.period_cnt - offset
                 : 8'(state.period_cnt + period - offset);
      assign ch_high[gi] = running && (pos < on_time);
    end
  endgenerate

  // ==========================================================
  // Frequency window check
  logic [12:0] tol_prod;
  logic [10:0] tol;
  logic [10:0] lo_bound;
  logic [10:0] hi_bound;
  logic in_range;
  assign tol_prod = 13'(sync_expect_count) * 13'(sync_window_pct);
  assign tol = 11'(tol_prod / 13'd100);
  assign lo_bound = (11'(sync_expect_count) > tol) ? 11'(sync_expect_count) - tol : 11'h000;
  assign hi_bound = 11'(sync_expect_count) + tol;
  assign in_range = (state.edge_cnt >= lo_bound) && (state.edge_cnt <= hi_bound); // [R8]

  // ==========================================================
  // Pin function and polarity
  logic [5:0] pol;
  logic [5:0] pin_level;
  logic [5:0][2:0] pin_fn;
  assign pol = i2c_mode ? 6'(pin_polarity & pcs_pkg::POL_I2C_MASK)
                        : 6'(pin_polarity & pcs_pkg::POL_MASK); // [R16] [R17]
  assign pin_fn = i2c_mode ? i2c_pin_function : otp_pin_function; // [R15]
  assign pin_level = state.pin_s2 ^ pol; // [R16]

  // ==========================================================
  // Next state
  always_comb begin
    logic ext_edge;
    logic tick;
    logic win_end;
    logic wrap;
    logic restart;
    logic [4:0] rails;
    logic good;
    ext_edge = 1'b0;
    tick = 1'b0;
    win_end = 1'b0;
    wrap = 1'b0;
    restart = 1'b0;
    rails = 5'h00;
    good = 1'b0;
    next_state = state;
    // Synchronisers: stage one feeds stage two only
    next_state.pin_s1 = pin_in;
    next_state.pin_s2 = state.pin_s1; // [R23]
    next_state.tog_s1 = link_toggle;
    next_state.tog_s2 = state.tog_s1;
    next_state.tog_s3 = state.tog_s2;
    ext_edge = state.tog_s2 ^ state.tog_s3;
    // Modulator tick from the selected source
    tick = (state.src == pcs_pkg::PCS_EXTERNAL) ? ext_edge : 1'b1;
    wrap = tick && (state.period_cnt >= period_last);
    // Edge counting over a fixed window of system clocks
    win_end = (state.meas_cnt == pcs_pkg::MEAS_LAST);
    next_state.meas_cnt = state.meas_cnt + 10'h001;
    if (win_end) begin
      next_state.edge_cnt = 11'(ext_edge);
    end else if (ext_edge && state.edge_cnt != 11'h7FF) begin
      next_state.edge_cnt = state.edge_cnt + 11'h001;
    end
    // Source selection
    case (state.src)
      pcs_pkg::PCS_BOOT: begin
        // Internal until configuration has loaded, whatever the mode
        if (config_loaded) begin
          next_state.src = sync_mode[pcs_pkg::SYNC_USE_EXT] ? pcs_pkg::PCS_MEASURE
                                                            : pcs_pkg::PCS_INTERNAL; // [R7] [R12]
        end
      end
      pcs_pkg::PCS_INTERNAL: begin
        if (sync_mode[pcs_pkg::SYNC_USE_EXT]) begin
          next_state.src = pcs_pkg::PCS_MEASURE; // [R6]
        end
      end
      pcs_pkg::PCS_MEASURE: begin
        if (!sync_mode[pcs_pkg::SYNC_USE_EXT]) begin
          next_state.src = pcs_pkg::PCS_INTERNAL;
        end else if (win_end && in_range) begin
          next_state.src = pcs_pkg::PCS_ARMED; // [R8]
        end
        // Out of window: keep internal and measure again
      end // [R9]
      pcs_pkg::PCS_ARMED: begin
        // Hand over at the end of an internal period, or at once while the divider is zero
        if (!sync_mode[pcs_pkg::SYNC_USE_EXT]) begin
          next_state.src = pcs_pkg::PCS_INTERNAL;
        end else if (wrap || !div_ok) begin
          next_state.src = pcs_pkg::PCS_EXTERNAL; // [R22] [R12] [R13]
          restart = 1'b1;
        end
      end
      pcs_pkg::PCS_EXTERNAL: begin
        // A dead clock leaves no boundary to wait for, so the period restarts
        if (!sync_mode[pcs_pkg::SYNC_USE_EXT]
            || (win_end && !in_range && sync_mode[pcs_pkg::SYNC_AUTO_BACK])) begin
          next_state.src = pcs_pkg::PCS_INTERNAL; // [R10] [R22]
          restart = 1'b1;
        end
      end
      default: begin
        next_state.src = pcs_pkg::PCS_BOOT;
      end
    endcase
    // Period counter: a restart, a halt or a wrap all return it to zero
    if (restart || !div_ok || wrap) begin
      next_state.period_cnt = 8'h00;
    end else if (tick) begin
      next_state.period_cnt = state.period_cnt + 8'h01;
    end
    // Drivers: a restart forces both switches off for one cycle
    next_state.high_side = restart ? 4'h0 : ch_high;
    next_state.low_side = (restart || !running) ? 4'h0 : ~ch_high; // [R2]
    // Master forwarding of the working clock and period start
    if (running && sync_mode[pcs_pkg::SYNC_MASTER]) begin
      if (tick) begin
        next_state.clk_fwd = ~state.clk_fwd; // [R11] [R13]
      end
      next_state.sync_pulse = wrap; // [R11]
    end else begin
      next_state.clk_fwd = 1'b0;
      next_state.sync_pulse = 1'b0;
    end
    // Rails and pins
    rails = i2c_rail_enable; // [R18]
    for (int i = 0; i < pcs_pkg::PINS; i++) begin
      next_state.pin_out[i] = pol[i];
      next_state.pin_oe[i] = 1'b0;
      case (pin_fn[i])
        pcs_pkg::PCS_FN_RAIL_EN: begin
          if (pin_level[i]) begin
            rails = rails | pin_rail_map[i]; // [R18]
          end
        end
        pcs_pkg::PCS_FN_PWR_GOOD: begin
          good = (pin_rail_map[i] != 5'h00)
              && ((rail_in_regulation & pin_rail_map[i]) == pin_rail_map[i]); // [R19]
          next_state.pin_out[i] = good ^ pol[i];
          next_state.pin_oe[i] = 1'b1;
        end
        pcs_pkg::PCS_FN_CLK_OUT: begin
          next_state.pin_out[i] = state.clk_fwd ^ pol[i];
          next_state.pin_oe[i] = config_loaded; // [R11]
        end
        pcs_pkg::PCS_FN_SYNC_OUT: begin
          next_state.pin_out[i] = state.sync_pulse ^ pol[i];
          next_state.pin_oe[i] = config_loaded; // [R11]
        end
        default: next_state.pin_oe[i] = 1'b0;
      endcase
    end
    next_state.rail_enable = rails;
    next_state.rail_good = rail_in_regulation; // [R19]
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign pin_out = state.pin_out;
  assign pin_oe = state.pin_oe;
  assign high_side = state.high_side;
  assign low_side = state.low_side;
  assign rail_enable = state.rail_enable;
  assign rail_good_status = state.rail_good;
  assign on_external = (state.src == pcs_pkg::PCS_EXTERNAL);
endmodule : pcs_ctrl

/* testbench/pcs_clk_src.sv */
// External clock source facing the controller's link_clock input pin.
// Assumes the bench sets run and slow; unrelated in phase to the system clock.
`timescale 1ns/1ps
module pcs_clk_src (
  // Control
  input wire logic run,
  input wire logic slow,
  // Clock out
  output logic link_clock
);
  // ==========================================================
  // Clock generation
  // Held low while stopped, so a dead source shows no stray edges
  initial begin
    link_clock = 1'b0;
    #3.7;
    forever begin
      if (run) begin
        link_clock = ~link_clock;
        #(slow ? 160.0 : 80.0);
      end else begin
        link_clock = 1'b0;
        #10;
      end
    end
  end
endmodule : pcs_clk_src

/* testbench/pcs_ctrl_props.sv */
// Checker for pcs_ctrl: gate timing, source choice and pin function relations.
// Assumes one system clock domain at the top ports; bound at the foot.
`timescale 1ns/1ps
module pcs_ctrl_props (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Configuration
  input wire logic config_loaded,
  input wire logic i2c_mode,
  input wire logic [7:0] switching_rate_select,
  input wire logic [2:0] sync_mode,
  input wire logic [5:0][2:0] otp_pin_function,
  input wire logic [5:0][2:0] i2c_pin_function,
  input wire logic [4:0] i2c_rail_enable,
  // Watched outputs
  input wire logic [3:0] high_side,
  input wire logic [3:0] low_side,
  input wire logic [5:0] pin_oe,
  input wire logic [4:0] rail_enable,
  input wire logic on_external
);
  // ==========================================================
  // Common timing
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic [2:0] div;
  // Divider zero halts the modulator, so it excuses cut pulses
  assign div = switching_rate_select[2:0];
  // ==========================================================
  // Assertions
  gate_excl_a: assert property ((high_side & low_side) == 4'h0)
    else $error("gates overlap");
  div_off_a: assert property (div == 3'h0 |=> high_side == 4'h0 && low_side == 4'h0)
    else $error("gates on at divider zero");
  boot_int_a: assert property (!config_loaded |-> !on_external)
    else $error("external before load");
  min_on_a: assert property ($rose(high_side[0]) && !on_external
    |-> (high_side[0] || div == 3'h0)[*4]) else $error("short pulse");
  sample_low_a: assert property ($fell(high_side[0]) && div != 3'h0
    && !on_external && !$past(on_external)
    |-> (!high_side[0] && (low_side[0] || div == 3'h0))[*8]
    ##1 (!high_side[0] && (low_side[0] || div == 3'h0))[*8]) else $error("short low");
  duty_cap_a: assert property ($rose(high_side[1]) && div == 3'h1 && !on_external
    |-> ##[1:15] !high_side[1]) else $error("duty above row cap");
  pin_idle_a: assert property ((i2c_mode ? i2c_pin_function[0] : otp_pin_function[0])
    == 3'h0 |=> !pin_oe[0]) else $error("idle pin driven");
  rail_serial_a: assert property (i2c_rail_enable[2] |=> rail_enable[2])
    else $error("serial rail enable lost");
  ext_cause_a: assert property ($rose(on_external) |-> $past(sync_mode[0]))
    else $error("external without request");
endmodule : pcs_ctrl_props
bind pcs_ctrl pcs_ctrl_props pcs_ctrl_props_i (.clock(clock), .reset_n(reset_n),
  .config_loaded(config_loaded), .i2c_mode(i2c_mode), .sync_mode(sync_mode),
  .switching_rate_select(switching_rate_select), .otp_pin_function(otp_pin_function),
  .i2c_pin_function(i2c_pin_function), .i2c_rail_enable(i2c_rail_enable),
  .high_side(high_side), .low_side(low_side), .pin_oe(pin_oe),
  .rail_enable(rail_enable), .on_external(on_external));

/* testbench/testbench.sv */
// Self-checking bench for pcs_ctrl: drives configuration levels, measures gates and pins.
// Assumes pcs_clk_src as the external clock and the bound pcs_ctrl_props checker.
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals
  logic clock, reset_n, config_loaded, i2c_mode, three, run, slow, on_external, link_clock;
  logic [7:0] rate, pol, expect_cnt;
  logic [2:0] sync_mode;
  logic [4:0] win_pct, rail_i2c, rail_ok, rail_enable, rail_good_status;
  logic [3:0][1:0] phase;
  logic [3:0][7:0] limit, req;
  logic [5:0][2:0] otp_fn, i2c_fn;
  logic [5:0][4:0] rail_map;
  logic [5:0] pin_in, pin_out, pin_oe;
  logic [3:0] high_side, low_side;
  int errors, checked, hi[4], rise[4], lo, tg, sp, n, p, lim, off;
  int pct[7] = '{47, 64, 72, 77, 80, 83, 85};
  // ==========================================================
  // Clock and instances
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  pcs_ctrl pcs_ctrl_i (.clock(clock), .reset_n(reset_n), .link_clock(link_clock),
    .config_loaded(config_loaded), .i2c_mode(i2c_mode), .switching_rate_select(rate),
    .sync_mode(sync_mode), .sync_expect_count(expect_cnt), .sync_window_pct(win_pct),
    .phase_mode_three(three), .phase_index(phase), .channel_duty_limit(limit),
    .duty_request(req), .pin_polarity(pol), .otp_pin_function(otp_fn),
    .i2c_pin_function(i2c_fn), .pin_rail_map(rail_map), .i2c_rail_enable(rail_i2c),
    .rail_in_regulation(rail_ok), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .high_side(high_side), .low_side(low_side), .rail_enable(rail_enable),
    .rail_good_status(rail_good_status), .on_external(on_external));
  pcs_clk_src pcs_clk_src_i (.run(run), .slow(slow), .link_clock(link_clock));
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      errors++;
      $display("BAD t=%0t got %h want %h", $time, got, want);
    end
  endtask : check
  // Drives land on the edge; settle samples after the edge's updates
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : settle
  // Counts gate, toggle and pulse cycles over a whole number of periods
  task automatic measure(input int len);
    logic [3:0] prev;
    logic pin_prev;
    #1;
    hi = '{0, 0, 0, 0};
    rise = '{-1, -1, -1, -1};
    lo = 0;
    tg = 0;
    sp = 0;
    prev = high_side;
    pin_prev = pin_out[2];
    for (int c = 0; c < len; c++) begin
      settle(1);
      lo += low_side[0];
      tg += (pin_out[2] != pin_prev);
      sp += pin_out[3];
      pin_prev = pin_out[2];
      for (int k = 0; k < 4; k++) begin
        hi[k] += high_side[k];
        if (high_side[k] && !prev[k] && rise[k] < 0) rise[k] = c;
      end
      prev = high_side;
    end
  endtask : measure
  // Bounded wait for the source flag; running out ends the run
  task automatic wait_ext(input logic want);
    // Step off the edge so the flag is read after the design has updated it
    #1;
    n = 0;
    while (on_external !== want) begin
      settle(1);
      n++;
      if (n > 3000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask : wait_ext
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    config_loaded = 1'b0;
    i2c_mode = 1'b0;
    three = 1'b0;
    run = 1'b1;
    slow = 1'b1;
    rate = 8'h00;
    pol = 8'h00;
    expect_cnt = 8'h40;
    sync_mode = 3'b101;
    win_pct = 5'h0A;
    rail_i2c = 5'h00;
    rail_ok = 5'h1F;
    phase = 8'hE4;
    limit = 32'hFF06_FFFF;
    req = 32'h0914_FF02;
    otp_fn = 18'h0_08C0;
    i2c_fn = 18'h0_0000;
    rail_map = 30'h0000_0000;
    pin_in = 6'h3F;
    tick(16);
    reset_n <= 1'b1;
    settle(1100);
    check(on_external, 1'b0);
    tick(1);
    config_loaded <= 1'b1;
    settle(2100);
    check(on_external, 1'b0);
    $display("test boot done");
    tick(1);
    sync_mode <= 3'b010;
    run <= 1'b0;
    // Every divider row, both phase modes; config moves only while halted
    for (int d = 1; d < 8; d++) begin
      tick(1);
      rate <= 8'h00;
      three <= (d > 3);
      tick(20);
      rate <= 8'(d);
      limit[3] <= 8'(32 * d * pct[d - 1] / 100);
      tick(40);
      p = 32 * d;
      lim = p * pct[d - 1] / 100;
      if (lim > p - 16) lim = p - 16;
      off = (d > 3) ? p / 3 : p / 4;
      measure(2 * p);
      check(hi[0], 8);
      check(hi[1], 2 * lim);
      check(hi[2], 12);
      check(hi[3], 18);
      check(lo, 2 * p - 8);
      for (int k = 1; k < 4; k++) begin
        check((rise[k] - rise[0] + p) % p, (k == 3 && d > 3) ? 0 : k * off);
      end
      check(tg, 2 * p);
      check(sp, 2);
      check(pin_oe[3:2], 2'h3);
      $display("test rate %0d done", d);
    end
    // Power good and rail enable pins, OTP then serial functions
    tick(1);
    pol <= 8'h3F;
    otp_fn <= 18'h1_000A;
    i2c_fn <= 18'h1_0008;
    rail_map <= 30'h0200_0223;
    rail_i2c <= 5'h04;
    settle(5);
    check({pin_oe[0], pin_out[5], pin_out[0]}, 3'b100);
    check(rail_enable, 5'h04);
    tick(1);
    i2c_mode <= 1'b1;
    settle(5);
    check({pin_oe[0], pin_out[5]}, 2'b01);
    tick(1);
    rail_ok <= 5'h1E;
    settle(5);
    check(pin_out[5], 1'b0);
    check(rail_good_status, 5'h1E);
    tick(1);
    pin_in <= 6'h3D;
    // Two synchroniser stages, then one register: new rails show on the third edge
    settle(2);
    check(rail_enable, 5'h04);
    settle(1);
    check(rail_enable, 5'h15);
    $display("test pins done");
    // Adopt, lose and keep the external source
    tick(1);
    sync_mode <= 3'b101;
    run <= 1'b1;
    slow <= 1'b0;
    wait_ext(1'b1);
    check(on_external, 1'b1);
    tick(1);
    run <= 1'b0;
    wait_ext(1'b0);
    check(on_external, 1'b0);
    tick(1);
    sync_mode <= 3'b001;
    run <= 1'b1;
    wait_ext(1'b1);
    check(on_external, 1'b1);
    tick(1);
    run <= 1'b0;
    settle(2100);
    check(on_external, 1'b1);
    tick(1);
    sync_mode <= 3'b000;
    wait_ext(1'b0);
    check(on_external, 1'b0);
    $display("test source done");
    report_and_stop();
  end
endmodule : testbench
